// *** design/dcs_chan.sv ***
// one dma channel: apb registers, request logic, read/write operand sequencer
//
// Summary of operation
// - incrementing address advances by 1, 2 or 4 per operand size
// - non-incrementing address stays unchanged after each operand
// - addresses still advance when a bus error ends the transfer
// - byte counter drops by 1, 2 or 4 when each operand completes
// - function codes loaded by software are driven on source and destination cycles
// - writing one to run bit starts the channel
// - internal request moves data at once after start
// - external request: no bus request until request input asserted
// - request input ignored while channel is not active
// - control field changes take effect at once while active
// - writing zero to run bit halts after the current bus cycle
// - a begun operand completes read and write before new requests; clearing run during its read drops the write
// - internal request bus cycles last two clocks
// - single-address mode runs one bus cycle per external request
//
// Design decisions made here: register access over APB and the register offsets.
`include "dcs_consts.svh"
`timescale 1ns/10ps
module dcs_chan
	import dcs_pkg::*;
(
	input  wire logic        mclk,                // system clock, 125 MHz
	input  wire logic        resetn,              // async reset, active low
	input  wire logic        psel,                // apb select
	input  wire logic        penable,             // apb access phase
	input  wire logic        pwrite,              // apb direction
	input  wire logic [11:0] paddr,               // apb byte address
	input  wire logic [31:0] pwdata,              // apb write data
	output logic      [31:0] prdata,              // apb read data
	output logic             pready,              // apb ready
	output logic             pslverr,             // apb error, unmapped address
	input  wire logic        transfer_request_in, // peripheral request, active high
	output logic             bus_req,             // bus request
	input  wire logic        bus_grant,           // bus granted
	output logic             bus_valid,           // bus cycle in progress
	output logic             bus_write,           // 1 write, 0 read
	output logic      [31:0] bus_addr,            // bus address
	output logic      [1:0]  bus_size,            // operand size code
	output logic      [2:0]  bus_fc,              // function code of cycle
	output logic      [31:0] bus_wdata,           // write data
	input  wire logic [31:0] bus_rdata,           // read data
	input  wire logic        bus_ack,             // cycle end
	input  wire logic        bus_err,             // cycle ended by bus error
	output logic             chan_active          // channel running
);
	typedef struct packed {
		logic [31:0] source_address_reg;
		logic [31:0] destination_address_reg;
		logic [31:0] byte_transfer_counter;
		logic [31:0] function_code_reg;
		logic [31:0] channel_control_reg;
		logic        st_done;
		logic        st_berr;
		dcs_state_t  state;
		logic        clk_cnt;
		logic        bus_valid;
		logic        bus_write;
		logic [31:0] bus_addr;
		logic [1:0]  bus_size;
		logic [2:0]  bus_fc;
		logic [31:0] bus_wdata;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} dcs_chan_st_t;

	dcs_chan_st_t s_q, s_d;

	logic        channel_run_bit;
	logic        ext_mode, single_mode;
	logic        source_addr_increment, dest_addr_increment;
	dcs_size_t   source_operand_size, dest_operand_size;
	logic [31:0] src_next, dst_next, src_step, dst_step;
	logic        wr_acc, rd_acc, req_ok, cyc_end;
	logic        fifo_in_ready, fifo_out_valid, fifo_pop;
	logic [31:0] fifo_out_data;

	assign channel_run_bit       = s_q.channel_control_reg[`DCS_CTL_RUN];
	assign ext_mode              = s_q.channel_control_reg[`DCS_CTL_EXT_REQ];
	assign single_mode           = s_q.channel_control_reg[`DCS_CTL_SINGLE];
	assign source_addr_increment = s_q.channel_control_reg[`DCS_CTL_SRC_INC];
	assign dest_addr_increment   = s_q.channel_control_reg[`DCS_CTL_DST_INC];
	assign source_operand_size   = dcs_size_t'(s_q.channel_control_reg[`DCS_CTL_SOURCE_OPERAND_SIZE_LO +: 2]);
	assign dest_operand_size     = dcs_size_t'(s_q.channel_control_reg[`DCS_CTL_DEST_OPERAND_SIZE_LO +: 2]);

	dcs_seq u_src (
		.addr_in  (s_q.source_address_reg),
		.inc_en   (source_addr_increment),
		.size     (source_operand_size),
		.addr_out (src_next),
		.step     (src_step)
	);

	dcs_seq u_dst (
		.addr_in  (s_q.destination_address_reg),
		.inc_en   (dest_addr_increment),
		.size     (dest_operand_size),
		.addr_out (dst_next),
		.step     (dst_step)
	);

	// read data waits here for its write cycle; a stalled write stalls new reads
	dcs_fifo #(.WIDTH(32), .DEPTH(4)) u_fifo (
		.mclk      (mclk),
		.resetn    (resetn),
		.flush     (s_q.state == DCS_IDLE),
		.in_valid  (s_q.state == DCS_RD_WAIT && cyc_end && !bus_err),
		.in_ready  (fifo_in_ready),
		.in_data   (bus_rdata),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	assign wr_acc = psel && penable && pwrite && !s_q.pready;
	assign rd_acc = psel && !penable && !pwrite;
	// request input only looked at while running
	// external mode waits on the request input
	assign req_ok = channel_run_bit && (!ext_mode || transfer_request_in)
		&& (s_q.byte_transfer_counter != 32'h0);
	// internal cycles end after two clocks; external ones on ack
	assign cyc_end = ext_mode ? (bus_ack || bus_err)
		: (s_q.clk_cnt || bus_err);
	assign fifo_pop = (s_q.state == DCS_WR_ADDR) && fifo_out_valid;

	always_comb begin
		s_d = s_q;
		s_d.pready = psel && !s_q.pready && penable;
		if (rd_acc) begin
			s_d.pslverr = 1'b0;
			unique case (paddr)
				`DCS_OFF_SRC_ADDR:  s_d.prdata = s_q.source_address_reg;
				`DCS_OFF_DST_ADDR:  s_d.prdata = s_q.destination_address_reg;
				`DCS_OFF_BYTE_CNT:  s_d.prdata = s_q.byte_transfer_counter;
				`DCS_OFF_FUNC_CODE: s_d.prdata = s_q.function_code_reg;
				`DCS_OFF_CONTROL:   s_d.prdata = s_q.channel_control_reg;
				`DCS_OFF_STATUS:    s_d.prdata = {29'h0, chan_active, s_q.st_berr,
					s_q.st_done};
				default: begin
					s_d.prdata  = `DCS_RESET_WORD;
					s_d.pslverr = 1'b1;
				end
			endcase
		end else if (psel && !penable) begin
			s_d.prdata  = `DCS_RESET_WORD;
			s_d.pslverr = !(paddr inside {`DCS_OFF_SRC_ADDR, `DCS_OFF_DST_ADDR,
				`DCS_OFF_BYTE_CNT, `DCS_OFF_FUNC_CODE, `DCS_OFF_STATUS,
				`DCS_OFF_CONTROL});
		end

		// sequencer: rule-driven updates come before software writes
		s_d.clk_cnt = 1'b0;
		unique case (s_q.state)
			DCS_IDLE: begin
				s_d.bus_valid = 1'b0;
				if (req_ok) s_d.state = DCS_RD_ADDR;
			end
			DCS_RD_ADDR: begin
				if (bus_grant && fifo_in_ready) begin
					s_d.bus_valid = 1'b1;
					s_d.bus_write = 1'b0;
					s_d.bus_addr  = s_q.source_address_reg;
					s_d.bus_size  = source_operand_size;
					// source function code on read cycles
					s_d.bus_fc    = s_q.function_code_reg[`DCS_FC_SRC_LO +: 3];
					s_d.state     = DCS_RD_WAIT;
				end
			end
			DCS_RD_WAIT: begin
				s_d.clk_cnt = 1'b1;
				if (cyc_end) begin
					s_d.bus_valid = 1'b0;
					// source advances even on bus error
					s_d.source_address_reg = src_next;
					if (bus_err) begin
						s_d.st_berr = 1'b1;
						s_d.destination_address_reg = dst_next;
						s_d.channel_control_reg[`DCS_CTL_RUN] = 1'b0;
						s_d.state = DCS_IDLE;
					end else if (single_mode) begin
						// one bus cycle per request in single-address mode
						s_d.byte_transfer_counter = s_q.byte_transfer_counter - src_step;
						s_d.state = DCS_IDLE;
					end else begin
						// the write follows before any new request
						s_d.state = DCS_WR_ADDR;
					end
				end
			end
			DCS_WR_ADDR: begin
				if (fifo_out_valid) begin
					s_d.bus_valid = 1'b1;
					s_d.bus_write = 1'b1;
					s_d.bus_addr  = s_q.destination_address_reg;
					s_d.bus_size  = dest_operand_size;
					// destination function code on write cycles
					s_d.bus_fc    = s_q.function_code_reg[`DCS_FC_DST_LO +: 3];
					s_d.bus_wdata = fifo_out_data;
					s_d.state     = DCS_WR_WAIT;
				end
			end
			DCS_WR_WAIT: begin
				s_d.clk_cnt = 1'b1;
				if (cyc_end) begin
					s_d.bus_valid = 1'b0;
					s_d.destination_address_reg = dst_next;
					s_d.byte_transfer_counter = s_q.byte_transfer_counter - dst_step;
					if (bus_err) begin
						s_d.st_berr = 1'b1;
						s_d.channel_control_reg[`DCS_CTL_RUN] = 1'b0;
					end
					s_d.state = DCS_IDLE;
				end
			end
		endcase

		// counter at zero ends the channel
		if (s_q.state == DCS_IDLE && channel_run_bit
			&& s_q.byte_transfer_counter == 32'h0) begin
			s_d.channel_control_reg[`DCS_CTL_RUN] = 1'b0;
			s_d.st_done = 1'b1;
		end

		if (wr_acc) begin
			unique case (paddr)
				`DCS_OFF_SRC_ADDR:  s_d.source_address_reg = pwdata;
				`DCS_OFF_DST_ADDR:  s_d.destination_address_reg = pwdata;
				`DCS_OFF_BYTE_CNT:  s_d.byte_transfer_counter = pwdata;
				`DCS_OFF_FUNC_CODE: s_d.function_code_reg = pwdata & `DCS_FC_MASK;
				// control changes act on the next clock
				// run cleared: current cycle finishes, then idle
				`DCS_OFF_CONTROL:   s_d.channel_control_reg = pwdata & `DCS_CTL_MASK;
				// write one to clear; a same-cycle set wins
				`DCS_OFF_STATUS: begin
					if (pwdata[`DCS_ST_DONE] && s_d.st_done == s_q.st_done)
						s_d.st_done = 1'b0;
					if (pwdata[`DCS_ST_BUS_ERR] && s_d.st_berr == s_q.st_berr)
						s_d.st_berr = 1'b0;
				end
				default: ;
			endcase
		end

		// a halted channel leaves only after its cycle ends
		if (!s_d.channel_control_reg[`DCS_CTL_RUN]
			&& (s_d.state == DCS_RD_ADDR || s_d.state == DCS_WR_ADDR))
			s_d.state = DCS_IDLE;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// request held whenever the channel wants the bus
	assign bus_req     = s_q.state != DCS_IDLE;
	assign bus_valid   = s_q.bus_valid;
	assign bus_write   = s_q.bus_write;
	assign bus_addr    = s_q.bus_addr;
	assign bus_size    = s_q.bus_size;
	assign bus_fc      = s_q.bus_fc;
	assign bus_wdata   = s_q.bus_wdata;
	assign prdata      = s_q.prdata;
	assign pready      = s_q.pready;
	assign pslverr     = s_q.pslverr;
	assign chan_active = channel_run_bit;

	default clocking dcs_cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	ext_req_gate_a: assert property (
		$rose(bus_req) && ext_mode |-> $past(transfer_request_in))
		else $error("bus requested without external request");
	idle_no_req_a: assert property (
		s_q.state == DCS_IDLE && !channel_run_bit |=> !bus_req)
		else $error("bus requested while stopped");
	int_cycle_len_a: assert property (
		$rose(bus_valid) && !ext_mode && !bus_err ##1 !ext_mode |=> !bus_valid)
		else $error("internal cycle not two clocks");
	cnt_step_a: assert property (
		s_q.state == DCS_WR_WAIT && cyc_end |=>
		s_q.byte_transfer_counter == $past(s_q.byte_transfer_counter) - $past(dst_step))
		else $error("counter step wrong");
	src_step_a: assert property (
		s_q.state == DCS_RD_WAIT && cyc_end && !wr_acc |=>
		s_q.source_address_reg == $past(src_next))
		else $error("source address step wrong");
	hold_addr_a: assert property (
		s_q.state == DCS_RD_WAIT && cyc_end && !source_addr_increment && !wr_acc |=>
		s_q.source_address_reg == $past(s_q.source_address_reg))
		else $error("held address changed");
	berr_adv_a: assert property (
		s_q.state == DCS_RD_WAIT && bus_err && dest_addr_increment && !wr_acc |=>
		s_q.destination_address_reg == $past(dst_next))
		else $error("address not advanced on bus error");
	write_follows_a: assert property (
		s_q.state == DCS_RD_WAIT && cyc_end && !bus_err && !single_mode |=>
		s_q.state == DCS_WR_ADDR || s_q.state == DCS_IDLE)
		else $error("read not followed by write");
	single_one_a: assert property (
		s_q.state == DCS_RD_WAIT && cyc_end && single_mode |=> s_q.state == DCS_IDLE)
		else $error("more than one cycle per request");
	zero_stop_a: assert property (
		s_q.state == DCS_IDLE && channel_run_bit && s_q.byte_transfer_counter == 32'h0
		&& !wr_acc |=> !channel_run_bit ##1 !bus_req)
		else $error("channel not stopped at zero count");
	fc_src_a: assert property (
		bus_valid && !bus_write |-> bus_fc == s_q.function_code_reg[2:0] || $past(wr_acc))
		else $error("source function code wrong");

	cov_full_c: cover property (s_q.state == DCS_WR_WAIT && cyc_end);
	cov_berr_c: cover property (bus_valid && bus_err);
	cov_done_c: cover property ($rose(s_q.st_done));
	cov_ext_c: cover property (ext_mode && $rose(bus_req));
endmodule

// *** design/dcs_consts.svh ***
// register offsets, field positions, reset values and timing counts of the dma channel
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH

`define DCS_OFF_SRC_ADDR   12'h000
`define DCS_OFF_DST_ADDR   12'h004
`define DCS_OFF_BYTE_CNT   12'h008
`define DCS_OFF_FUNC_CODE  12'h00c
`define DCS_OFF_STATUS     12'h010
`define DCS_OFF_CONTROL    12'h014

// control register fields
`define DCS_CTL_RUN        0
`define DCS_CTL_EXT_REQ    1
`define DCS_CTL_SRC_INC    2
`define DCS_CTL_DST_INC    3
`define DCS_CTL_SOURCE_OPERAND_SIZE_LO   4
`define DCS_CTL_DEST_OPERAND_SIZE_LO   6
`define DCS_CTL_SINGLE     8
`define DCS_CTL_MASK       32'h0000_01ff

// status register fields
`define DCS_ST_DONE        0
`define DCS_ST_BUS_ERR     1
`define DCS_ST_ACTIVE      2
`define DCS_ST_MASK        32'h0000_0003

// function code fields
`define DCS_FC_SRC_LO      0
`define DCS_FC_DST_LO      4
`define DCS_FC_MASK        32'h0000_0077

`define DCS_RESET_WORD     32'h0000_0000

// internal bus cycle length in clocks
`define DCS_INT_CYCLE_CLKS 2

`endif

// *** design/dcs_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module dcs_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input  wire logic             mclk,     // system clock
	input  wire logic             resetn,   // async reset, active low
	input  wire logic             flush,    // drop all entries
	input  wire logic             in_valid, // write side valid
	output logic                  in_ready, // write side ready
	input  wire logic [WIDTH-1:0] in_data,  // write data
	output logic                  out_valid,// read side valid
	input  wire logic             out_ready,// read side ready
	output logic      [WIDTH-1:0] out_data  // read data, read combinationally from storage at the read pointer
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} dcs_fifo_st_t;

	dcs_fifo_st_t s_q, s_d;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic push, pop;

	// count is one bit wider than the pointers, so full compares without wrap
	assign in_ready  = (s_q.cnt < (AW+1)'(DEPTH));
	assign out_valid = (s_q.cnt != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_q[s_q.rp];

	always_comb begin
		s_d = s_q;
		if (flush) begin
			s_d = '0;
		end else begin
			if (push) s_d.wp = s_q.wp + 1'b1;
			if (pop) s_d.rp = s_q.rp + 1'b1;
			s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// storage has no reset; only valid entries are ever read
	always_ff @(posedge mclk) begin
		if (push && !flush) mem_q[s_q.wp] <= in_data;
	end

	fifo_bound_a: assert property (@(posedge mclk) disable iff (!resetn)
		s_q.cnt <= (AW+1)'(DEPTH))
		else $error("fifo count above depth");
endmodule

// *** design/dcs_pkg.sv ***
// types shared by the dma channel design files
package dcs_pkg;

	typedef enum logic [1:0] {
		DCS_SZ_LONG,
		DCS_SZ_BYTE,
		DCS_SZ_WORD,
		DCS_SZ_RSVD
	} dcs_size_t;

	typedef enum logic [2:0] {
		DCS_IDLE,
		DCS_RD_ADDR,
		DCS_RD_WAIT,
		DCS_WR_ADDR,
		DCS_WR_WAIT
	} dcs_state_t;

endpackage

// *** design/dcs_seq.sv ***
// address and byte counter step unit for one dma operand
`timescale 1ns/10ps
module dcs_seq
	import dcs_pkg::*;
(
	input  wire logic      [31:0] addr_in,  // current address
	input  wire logic             inc_en,   // increment enabled
	input  wire dcs_pkg::dcs_size_t size,   // operand size
	output logic           [31:0] addr_out, // next address
	output logic           [31:0] step      // bytes of one operand
);
	always_comb begin
		unique case (size)
			DCS_SZ_BYTE: step = 32'h0000_0001;
			DCS_SZ_WORD: step = 32'h0000_0002;
			default:     step = 32'h0000_0004;
		endcase
		addr_out = inc_en ? addr_in + step : addr_in;
	end
endmodule

// *** tb/dcs_bus_model.sv ***
// far-side model of the dma channel: arbiter, address-derived read data and cycle terminator
`timescale 1ns/10ps
module dcs_bus_model (
	input  wire logic        mclk,      // system clock
	input  wire logic        resetn,    // async reset, active low
	input  wire logic        bus_req,   // channel asks for the bus
	output logic             bus_grant, // bus granted
	input  wire logic        bus_valid, // cycle in progress
	input  wire logic        bus_write, // 1 write cycle
	input  wire logic [31:0] bus_addr,  // cycle address
	input  wire logic [1:0]  bus_size,  // operand size code
	input  wire logic [2:0]  bus_fc,    // function code of cycle
	input  wire logic [31:0] bus_wdata, // write data
	output logic      [31:0] bus_rdata, // read data
	output logic             bus_ack,   // cycle end
	output logic             bus_err,   // cycle end by bus error
	input  wire logic [3:0]  ack_dly,   // wait states before the answer
	input  wire logic        err_arm    // answer with an error instead
);
	int          n_rd;
	int          n_wr;
	int          len;
	int          last_len;
	logic [31:0] rd_addr;
	logic [31:0] wr_addr;
	logic [31:0] wr_data;
	logic [31:0] pat;
	logic [2:0]  rd_fc;
	logic [2:0]  wr_fc;
	logic [1:0]  rd_size;

	// no stale data outside read cycles, so a late sample is caught
	assign bus_rdata = (bus_valid && !bus_write) ? (bus_addr ^ 32'hc3c3_0000) : pat;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bus_grant <= 1'b0;
			bus_ack   <= 1'b0;
			bus_err   <= 1'b0;
			pat       <= 32'h5555_aaaa;
			n_rd      <= 0;
			n_wr      <= 0;
			len       <= 0;
			last_len  <= 0;
		end else begin
			bus_grant <= bus_req;
			pat       <= ~pat;
			bus_ack   <= 1'b0;
			bus_err   <= 1'b0;
			if (bus_valid) begin
				len <= len + 1;
				if (len == int'(ack_dly)) begin
					bus_ack <= !err_arm;
					bus_err <= err_arm;
				end
				if (len == 0 && bus_write) begin
					n_wr    <= n_wr + 1;
					wr_addr <= bus_addr;
					wr_data <= bus_wdata;
					wr_fc   <= bus_fc;
				end else if (len == 0) begin
					n_rd    <= n_rd + 1;
					rd_addr <= bus_addr;
					rd_fc   <= bus_fc;
					rd_size <= bus_size;
				end
			end else if (len != 0) begin
				last_len <= len;
				len      <= 0;
			end
		end
	end
endmodule

// *** tb/dcs_chan_tb.sv ***
// self-checking bench for the dma channel and its far-side model
`include "dcs_consts.svh"
`timescale 1ns/10ps
module dcs_chan_tb;
	logic        mclk = 1'b0;
	logic        resetn, psel, penable, pwrite, pready, pslverr, req_in;
	logic        bus_req, bus_grant, bus_valid, bus_write, bus_ack, bus_err;
	logic        chan_active, err_arm, e, s, di;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, bus_addr, bus_wdata, bus_rdata, r;
	logic [1:0]  bus_size, sz;
	logic [2:0]  bus_fc;
	logic [3:0]  ack_dly;
	int          errors = 0;
	int          num_checks = 0;
	int          cycles = 0;
	int          n0, w0, r1, step;

	dcs_chan dcs_chan_inst (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .transfer_request_in(req_in), .bus_req, .bus_grant,
		.bus_valid, .bus_write, .bus_addr, .bus_size, .bus_fc, .bus_wdata, .bus_rdata,
		.bus_ack, .bus_err, .chan_active);
	dcs_bus_model dcs_bus_model_inst (.mclk, .resetn, .bus_req, .bus_grant, .bus_valid,
		.bus_write, .bus_addr, .bus_size, .bus_fc, .bus_wdata, .bus_rdata, .bus_ack,
		.bus_err, .ack_dly, .err_arm);

	always #4 mclk = ~mclk;

	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			test_done;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic er);
		int n;
		@(posedge mclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        er;
		apb(1'b1, a, d, rd, er);
	endtask

	task automatic reg_chk(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] rd;
		logic        er;
		apb(1'b0, a, 32'h0, rd, er);
		check(rd, x);
	endtask

	function automatic logic [31:0] ctl(input logic run, ext, dinc, input logic [1:0] size,
			input logic sg);
		ctl = 32'h0;
		ctl[`DCS_CTL_RUN]           = run;
		ctl[`DCS_CTL_EXT_REQ]       = ext;
		ctl[`DCS_CTL_SRC_INC]       = 1'b1;
		ctl[`DCS_CTL_DST_INC]       = dinc;
		ctl[`DCS_CTL_SOURCE_OPERAND_SIZE_LO +: 2] = size;
		ctl[`DCS_CTL_DEST_OPERAND_SIZE_LO +: 2] = size;
		ctl[`DCS_CTL_SINGLE]        = sg;
	endfunction

	task automatic prog(input logic [31:0] sa, da, cnt, k);
		reg_wr(`DCS_OFF_STATUS, 32'h3);
		reg_wr(`DCS_OFF_SRC_ADDR, sa);
		reg_wr(`DCS_OFF_DST_ADDR, da);
		reg_wr(`DCS_OFF_BYTE_CNT, cnt);
		reg_wr(`DCS_OFF_FUNC_CODE, 32'h52);
		reg_wr(`DCS_OFF_CONTROL, k);
		n0 = dcs_bus_model_inst.n_rd;
		w0 = dcs_bus_model_inst.n_wr;
	endtask

	task automatic wait_stop;
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (chan_active !== 1'b0 && n < 2000);
		repeat (4) @(posedge mclk);
	endtask

	task automatic wait_wr(input int t);
		int n;
		n = 0;
		while (dcs_bus_model_inst.n_wr < t && n < 1000) begin
			@(posedge mclk);
			n++;
		end
	endtask

	task automatic no_req(output logic seen);
		seen = 1'b0;
		repeat (16) begin
			@(posedge mclk);
			seen = seen | bus_req;
		end
	endtask

	initial begin
		resetn  = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0;
		req_in  = 1'b0;
		ack_dly = 4'h0;
		err_arm = 1'b0;
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			reg_chk(12'(4 * i), `DCS_RESET_WORD);
		end
		apb(1'b1, 12'h018, 32'hffff_ffff, r, e);
		apb(1'b0, 12'h018, 32'h0, r, e);
		check(e, 1'b1);
		check(r, 32'h0);
		reg_wr(`DCS_OFF_FUNC_CODE, 32'hffff_ffff);
		reg_chk(`DCS_OFF_FUNC_CODE, `DCS_FC_MASK);
		reg_wr(`DCS_OFF_CONTROL, 32'hffff_fffe);
		reg_chk(`DCS_OFF_CONTROL, 32'h0000_01fe);
		check(chan_active, 1'b0);
		$display("test registers done");
		for (int k = 0; k < 3; k++) begin
			sz   = (k == 2) ? 2'h0 : 2'(k + 1);
			step = 1 << k;
			di   = (k != 0);
			prog(32'h1000, 32'h2000, 32'(2 * step), ctl(1'b1, 1'b0, di, sz, 1'b0));
			wait_stop;
			check(dcs_bus_model_inst.n_rd - n0, 32'h2);
			check(dcs_bus_model_inst.rd_addr, 32'h1000 + step);
			check(dcs_bus_model_inst.wr_addr, di ? 32'h2000 + step : 32'h2000);
			check(dcs_bus_model_inst.rd_fc, 32'h2);
			check(dcs_bus_model_inst.wr_fc, 32'h5);
			check(dcs_bus_model_inst.rd_size, sz);
			check(dcs_bus_model_inst.last_len, 32'h2);
			if (k == 2) check(dcs_bus_model_inst.wr_data, 32'hc3c3_1004);
			reg_chk(`DCS_OFF_SRC_ADDR, 32'h1000 + 2 * step);
			reg_chk(`DCS_OFF_DST_ADDR, di ? 32'h2000 + 2 * step : 32'h2000);
			reg_chk(`DCS_OFF_BYTE_CNT, 32'h0);
			reg_chk(`DCS_OFF_STATUS, 32'h1);
			check(chan_active, 1'b0);
		end
		$display("test internal sizes done");
		req_in <= 1'b1;
		prog(32'h1100, 32'h2100, 32'h4, ctl(1'b0, 1'b1, 1'b1, 2'h0, 1'b0));
		no_req(s);
		check(s, 1'b0);
		req_in <= 1'b0;
		reg_wr(`DCS_OFF_CONTROL, ctl(1'b1, 1'b1, 1'b1, 2'h0, 1'b0));
		no_req(s);
		check(s, 1'b0);
		ack_dly <= 4'h3;
		req_in  <= 1'b1;
		wait_stop;
		check(dcs_bus_model_inst.n_wr - w0, 32'h1);
		check(dcs_bus_model_inst.wr_addr, 32'h2100);
		reg_chk(`DCS_OFF_BYTE_CNT, 32'h0);
		prog(32'h1200, 32'h2200, 32'h8, ctl(1'b1, 1'b1, 1'b1, 2'h0, 1'b1));
		wait_stop;
		req_in <= 1'b0;
		check(dcs_bus_model_inst.n_rd - n0, 32'h2);
		check(dcs_bus_model_inst.n_wr - w0, 32'h0);
		reg_chk(`DCS_OFF_SRC_ADDR, 32'h1208);
		$display("test external done");
		ack_dly <= 4'h0;
		err_arm <= 1'b1;
		prog(32'h3000, 32'h4000, 32'h8, ctl(1'b1, 1'b0, 1'b1, 2'h0, 1'b0));
		wait_stop;
		err_arm <= 1'b0;
		reg_chk(`DCS_OFF_SRC_ADDR, 32'h3004);
		reg_chk(`DCS_OFF_DST_ADDR, 32'h4004);
		apb(1'b0, `DCS_OFF_STATUS, 32'h0, r, e);
		check(r & 32'h2, 32'h2);
		reg_wr(`DCS_OFF_STATUS, 32'h3);
		reg_chk(`DCS_OFF_STATUS, 32'h0);
		$display("test bus error done");
		prog(32'h5000, 32'h6000, 32'h40, ctl(1'b1, 1'b0, 1'b1, 2'h0, 1'b0));
		wait_wr(w0 + 2);
		reg_wr(`DCS_OFF_CONTROL, ctl(1'b1, 1'b1, 1'b1, 2'h0, 1'b0));
		repeat (20) @(posedge mclk);
		r1 = dcs_bus_model_inst.n_rd;
		repeat (20) @(posedge mclk);
		check(dcs_bus_model_inst.n_rd, r1);
		check(dcs_bus_model_inst.n_rd - n0, dcs_bus_model_inst.n_wr - w0);
		check(chan_active, 1'b1);
		req_in <= 1'b1;
		wait_wr(dcs_bus_model_inst.n_wr + 2);
		reg_wr(`DCS_OFF_CONTROL, ctl(1'b0, 1'b1, 1'b1, 2'h0, 1'b0));
		repeat (20) @(posedge mclk);
		r1 = dcs_bus_model_inst.n_rd;
		repeat (20) @(posedge mclk);
		req_in <= 1'b0;
		check(dcs_bus_model_inst.n_rd, r1);
		check(chan_active, 1'b0);
		reg_chk(`DCS_OFF_BYTE_CNT, 32'(64 - 4 * (dcs_bus_model_inst.n_wr - w0)));
		$display("test live change and halt done");
		// read data passes the internal buffer on its way to the write cycle
		prog(32'h7000, 32'h8000, 32'h10, ctl(1'b1, 1'b0, 1'b1, 2'h0, 1'b0));
		wait_stop;
		check(dcs_bus_model_inst.n_rd - n0, 32'h4);
		check(dcs_bus_model_inst.n_wr - w0, 32'h4);
		check(dcs_bus_model_inst.wr_addr, 32'h800c);
		check(dcs_bus_model_inst.wr_data, 32'hc3c3_700c);
		reg_chk(`DCS_OFF_DST_ADDR, 32'h8010);
		reg_chk(`DCS_OFF_BYTE_CNT, 32'h0);
		$display("test buffered data done");
		test_done;
	end
endmodule
